// ===== verilog/irq_pending_pkg.sv
// constants shared by the pending-request capture logic
package irq_pending_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int NUM_SRC = 16;
    // register map
    localparam logic [11:0] PERIPH_PEND_ADDR = 12'hFC0;
    localparam logic [11:0] PERIPH_EN_HIGH_ADDR = 12'hFC1;
    localparam logic [11:0] PERIPH_EN_LOW_ADDR = 12'hFC2;
    localparam logic [11:0] PORT_PEND_ADDR = 12'hFC3;
    localparam logic [11:0] PORT_EN_HIGH_ADDR = 12'hFC4;
    localparam logic [11:0] PORT_EN_LOW_ADDR = 12'hFC5;
    localparam logic [11:0] CONTROL_ADDR = 12'hFCF;
    localparam logic [11:0] EVENT_STATUS_ADDR = 12'hFD0;
    localparam logic [11:0] EVENT_MASK_ADDR = 12'hFD1;
    // reset values
    localparam logic [7:0] PEND_RESET = 8'h00;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // control register field
    localparam int GIE_BIT = 7;
    // event status fields
    localparam int EV_PERIPH_BIT = 0;
    localparam int EV_PORT_BIT = 1;
    localparam int EV_VECTOR_BIT = 2;
    localparam int EV_W = 3;
    // priority level encoding
    typedef enum logic [1:0] {
        LEVEL_OFF = 2'b00,
        LEVEL_ONE = 2'b01,
        LEVEL_TWO = 2'b10,
        LEVEL_THREE = 2'b11
    } level_type;
    localparam logic [3:0] NO_SOURCE = 4'hF;
endpackage

// ===== verilog/pending_byte.sv
// one byte of pending request flags with hardware set, ack clear and bus write
`timescale 1ns/10ps
`default_nettype none
module pending_byte
#(
    parameter int WIDTH = 8,
    parameter logic [7:0] RESET_VALUE = 8'h00
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // hardware side
    input wire logic [WIDTH-1:0] pulse,
    input wire logic [WIDTH-1:0] ack,
    // software side
    input wire logic write,
    input wire logic [WIDTH-1:0] write_data,
    // state
    output logic [WIDTH-1:0] pending
);
    logic [WIDTH-1:0] next_pending;

    always_comb
    begin
        next_pending = pending & ~ack;
        if (write)
        begin
            // written byte replaces the register whole
            next_pending = write_data;
        end
        // a pulse in the same cycle as a clear still wins
        next_pending = next_pending | pulse;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pending <= RESET_VALUE[WIDTH-1:0];
        else
            pending <= next_pending;
    end
endmodule
`default_nettype wire

// ===== verilog/interrupt_request_pending_regs.sv
// pending-request registers with enable, priority and core request logic
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - pulse sets matching pending bit
// - core acknowledge clears pending bit
// - writing zero clears a pending bit
// - writing one raises a software request
// - pending writes store byte as given, ORed with any same-cycle pulse
// - global enable forwards enabled pending requests
// - disabled: bits still captured and readable
// - watchdog and oscillator traps bypass registers
// - peripheral register bit mapping, reset zero
// - port register bit mapping, reset zero
// - pending bits read one when waiting
// - global enable set and clear actions
// - enable pair encodes off and levels
module interrupt_request_pending_regs
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [irq_pending_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [irq_pending_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [irq_pending_pkg::DATA_W-1:0] reg_rdata,
    // peripheral request pulses
    input wire logic timer2_pulse,
    input wire logic timer1_pulse,
    input wire logic timer0_pulse,
    input wire logic serial0_receive_pulse,
    input wire logic serial0_transmit_pulse,
    input wire logic two_wire_pulse,
    input wire logic serial_periph_pulse,
    input wire logic converter_pulse,
    // port request pulses
    input wire logic pin_a7_or_lowvolt_pulse,
    input wire logic pin_a6_or_comp0_pulse,
    input wire logic pin_a5_or_comp1_pulse,
    input wire logic [3:0] shared_port_pin_pulse,
    input wire logic pin_a0_pulse,
    // core instruction events
    input wire logic enable_interrupt_exec,
    input wire logic interrupt_return_exec,
    input wire logic disable_interrupt_exec,
    input wire logic trap_exec,
    // core request and acknowledge
    input wire logic core_ack,
    output logic core_request,
    output logic [3:0] core_source,
    output logic [1:0] core_level,
    output logic global_interrupt_enable,
    // software event interrupt
    output logic event_irq
);
    import irq_pending_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [7:0] peripheral_request_pending;
    logic [7:0] port_request_pending;
    logic [7:0] periph_en_high;
    logic [7:0] periph_en_low;
    logic [7:0] port_en_high;
    logic [7:0] port_en_low;
    logic [EV_W-1:0] event_status;
    logic [EV_W-1:0] event_mask;
    logic [NUM_SRC-1:0] ack_vec;
    logic [7:0] periph_pulse;
    logic [7:0] port_pulse;
    logic [3:0] next_source;
    logic [1:0] next_level;
    logic [1:0] best_level;
    logic [3:0] best_source;
    logic [NUM_SRC-1:0] all_pending;
    logic [NUM_SRC-1:0] all_high;
    logic [NUM_SRC-1:0] all_low;
    logic [EV_W-1:0] event_set;
    logic ack_taken;
    logic [7:0] periph_ack;
    logic [7:0] port_ack;
    logic request_valid;
    logic gie_clear;
    logic gie_set;
    logic periph_pend_write;
    logic port_pend_write;
    logic periph_high_write;
    logic periph_low_write;
    logic port_high_write;
    logic port_low_write;
    logic control_write;
    logic status_write;
    logic mask_write;
    logic [DATA_W-1:0] next_rdata;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [11:0] target);
        hit = (addr == target);
    endfunction

    // enable pair of one source read as its priority level
    function automatic logic [1:0] level_of(input logic high,
                                            input logic low);
        level_of = {high, low};
    endfunction

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    assign periph_pend_write = reg_write && hit(reg_addr, PERIPH_PEND_ADDR);
    assign port_pend_write = reg_write && hit(reg_addr, PORT_PEND_ADDR);
    assign periph_high_write = reg_write && hit(reg_addr, PERIPH_EN_HIGH_ADDR);
    assign periph_low_write = reg_write && hit(reg_addr, PERIPH_EN_LOW_ADDR);
    assign port_high_write = reg_write && hit(reg_addr, PORT_EN_HIGH_ADDR);
    assign port_low_write = reg_write && hit(reg_addr, PORT_EN_LOW_ADDR);
    assign control_write = reg_write && hit(reg_addr, CONTROL_ADDR);
    assign status_write = reg_write && hit(reg_addr, EVENT_STATUS_ADDR);
    assign mask_write = reg_write && hit(reg_addr, EVENT_MASK_ADDR);

    // ------------------------------------------------------------
    // pending request bytes
    // ------------------------------------------------------------
    // bit order: 7 timer2 down to 0 converter
    assign periph_pulse = {timer2_pulse, timer1_pulse, timer0_pulse,
                           serial0_receive_pulse, serial0_transmit_pulse,
                           two_wire_pulse, serial_periph_pulse,
                           converter_pulse};
    // bit order: 7 a7/low volt, 6 a6/comp0, 5 a5/comp1, 4..1 shared, 0 a0
    assign port_pulse = {pin_a7_or_lowvolt_pulse, pin_a6_or_comp0_pulse,
                         pin_a5_or_comp1_pulse, shared_port_pin_pulse,
                         pin_a0_pulse};

    // a load, mask and store from software drops any pulse landing
    // between its read and its write; the write replaces the whole byte
    pending_byte #(.WIDTH(8), .RESET_VALUE(PEND_RESET)) periph_bits
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pulse(periph_pulse),
        .ack(periph_ack),
        .write(periph_pend_write),
        .write_data(reg_wdata),
        .pending(peripheral_request_pending)
    );

    pending_byte #(.WIDTH(8), .RESET_VALUE(PEND_RESET)) port_bits
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pulse(port_pulse),
        .ack(port_ack),
        .write(port_pend_write),
        .write_data(reg_wdata),
        .pending(port_request_pending)
    );

    // ------------------------------------------------------------
    // enable and priority registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            periph_en_high <= EN_RESET;
        else if (periph_high_write)
            periph_en_high <= reg_wdata;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            periph_en_low <= EN_RESET;
        else if (periph_low_write)
            periph_en_low <= reg_wdata;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            port_en_high <= EN_RESET;
        else if (port_high_write)
            port_en_high <= reg_wdata;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            port_en_low <= EN_RESET;
        else if (port_low_write)
            port_en_low <= reg_wdata;
    end

    // ------------------------------------------------------------
    // global enable
    // ------------------------------------------------------------
    assign ack_taken = core_ack && core_request;
    // every disabling action beats a control write or an enable instruction
    assign gie_clear = disable_interrupt_exec || trap_exec || ack_taken;
    assign gie_set = enable_interrupt_exec || interrupt_return_exec;

    // traps and the watchdog never reach the pending bytes; here they
    // only drop the global enable
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            global_interrupt_enable <= 1'b0;
        else if (gie_clear)
            global_interrupt_enable <= 1'b0;
        else if (control_write)
            global_interrupt_enable <= reg_wdata[GIE_BIT];
        else if (gie_set)
            global_interrupt_enable <= 1'b1;
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    // source index 15 is peripheral bit 7 (highest within a level), 0 is pin a0
    assign all_pending = {peripheral_request_pending, port_request_pending};
    assign all_high = {periph_en_high, port_en_high};
    assign all_low = {periph_en_low, port_en_low};

    always_comb
    begin
        best_level = LEVEL_OFF;
        best_source = NO_SOURCE;
        // ascending scan with >= lets the higher index win ties
        // level 3 beats lower levels; index order only breaks a tie
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (all_pending[i] && level_of(all_high[i], all_low[i]) != LEVEL_OFF
                && level_of(all_high[i], all_low[i]) >= best_level)
            begin
                best_level = level_of(all_high[i], all_low[i]);
                best_source = 4'(i);
            end
        end
    end

    // request only while enabled; pending bits keep capturing regardless
    assign next_level = global_interrupt_enable ? best_level : LEVEL_OFF;
    assign request_valid = (next_level != LEVEL_OFF);
    assign next_source = request_valid ? best_source : NO_SOURCE;

    // dropped for the cycle after an ack so the cleared bit is not reissued
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            core_request <= 1'b0;
        else
            core_request <= request_valid && !ack_taken;
    end

    // source and level stay registered so the core sees one steady vector
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            core_source <= NO_SOURCE;
        else
            core_source <= next_source;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            core_level <= LEVEL_OFF;
        else
            core_level <= next_level;
    end

    // acknowledge clears only the source being serviced
    always_comb
    begin
        ack_vec = '0;
        if (ack_taken)
            ack_vec[core_source] = 1'b1;
    end
    assign periph_ack = ack_vec[15:8];
    assign port_ack = ack_vec[7:0];

    // ------------------------------------------------------------
    // event status and mask
    // ------------------------------------------------------------
    // trap sources never enter these registers and are handled by the core
    assign event_set[EV_PERIPH_BIT] = |periph_pulse;
    assign event_set[EV_PORT_BIT] = |port_pulse;
    assign event_set[EV_VECTOR_BIT] = ack_taken;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            event_status <= '0;
        else if (status_write)
            event_status <= (event_status & ~reg_wdata[EV_W-1:0]) | event_set;
        else
            event_status <= event_status | event_set;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            event_mask <= '0;
        else if (mask_write)
            event_mask <= reg_wdata[EV_W-1:0];
    end

    assign event_irq = |(event_status & event_mask);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // idle cycles and unmapped addresses read as zero
    always_comb
    begin
        next_rdata = READ_UNMAPPED;
        if (reg_read)
        begin
            case (reg_addr)
                PERIPH_PEND_ADDR: next_rdata = peripheral_request_pending;
                PORT_PEND_ADDR: next_rdata = port_request_pending;
                PERIPH_EN_HIGH_ADDR: next_rdata = periph_en_high;
                PERIPH_EN_LOW_ADDR: next_rdata = periph_en_low;
                PORT_EN_HIGH_ADDR: next_rdata = port_en_high;
                PORT_EN_LOW_ADDR: next_rdata = port_en_low;
                CONTROL_ADDR: next_rdata = {global_interrupt_enable, 7'h00};
                EVENT_STATUS_ADDR: next_rdata = {5'h00, event_status};
                EVENT_MASK_ADDR: next_rdata = {5'h00, event_mask};
                default: next_rdata = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= READ_UNMAPPED;
        else
            reg_rdata <= next_rdata;
    end
endmodule
`default_nettype wire

// ===== bench/irq_pending_chk.sv
// assertion checker bound to the pending-request block
`timescale 1ns/10ps
`default_nettype none
module irq_pending_chk
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // events and core side
    input wire logic timer2_pulse,
    input wire logic enable_interrupt_exec,
    input wire logic disable_interrupt_exec,
    input wire logic trap_exec,
    input wire logic core_ack,
    input wire logic core_request,
    input wire logic [1:0] core_level,
    input wire logic global_interrupt_enable
);
    import irq_pending_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    AST_ACK_DROPS: assert property (
        core_request && core_ack |=> !core_request && !global_interrupt_enable)
        else $error("accepted ack left request or enable up");
    AST_OFF: assert property (
        disable_interrupt_exec || trap_exec |=> !global_interrupt_enable)
        else $error("global enable survived disable or trap");
    AST_ON: assert property (
        enable_interrupt_exec && !disable_interrupt_exec && !trap_exec && !reg_write
        && !core_ack |=> global_interrupt_enable)
        else $error("enable instruction did not set global enable");
    AST_GATED: assert property (
        !global_interrupt_enable [*2] |-> !core_request)
        else $error("request raised while globally disabled");
    AST_LEVEL: assert property (
        core_request |-> core_level != LEVEL_OFF)
        else $error("request shown with level off");
    AST_RDATA_IDLE: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_CAPTURE: assert property (
        timer2_pulse ##1 (!core_ack && !reg_write)
        ##1 (reg_read && reg_addr == PERIPH_PEND_ADDR) |=> reg_rdata[7])
        else $error("timer2 pulse not captured");
    AST_WRITE_ZERO: assert property (
        reg_write && reg_addr == PERIPH_PEND_ADDR && !reg_wdata[7] && !timer2_pulse
        ##1 (!timer2_pulse && !reg_write)
        ##1 (reg_read && reg_addr == PERIPH_PEND_ADDR) |=> !reg_rdata[7])
        else $error("written zero did not clear timer2 bit");
endmodule
bind interrupt_request_pending_regs irq_pending_chk u_chk (.ref_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .timer2_pulse, .enable_interrupt_exec,
    .disable_interrupt_exec, .trap_exec, .core_ack, .core_request, .core_level,
    .global_interrupt_enable);
`default_nettype wire

// ===== bench/core_model.sv
// processor core model: acknowledges requests, returns after a short service
`timescale 1ns/10ps
`default_nettype none
module core_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // request side
    input wire logic core_request,
    input wire logic [3:0] core_source,
    input wire logic [3:0] ack_delay,
    // answers
    output logic core_ack,
    output logic interrupt_return_exec,
    output logic [3:0] served_source,
    output logic [7:0] served_count
);
    logic [3:0] wait_cnt;
    logic [2:0] busy_cnt;
    // no new ack while a handler runs, as a real core would
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            core_ack <= 1'b0;
            interrupt_return_exec <= 1'b0;
            served_source <= 4'h0;
            served_count <= 8'h00;
            wait_cnt <= 4'h0;
            busy_cnt <= 3'h0;
        end
        else
        begin
            core_ack <= 1'b0;
            interrupt_return_exec <= (busy_cnt == 3'h1);
            if (busy_cnt != 3'h0)
                busy_cnt <= busy_cnt - 3'h1;
            else if (core_request && wait_cnt == ack_delay)
            begin
                core_ack <= 1'b1;
                served_source <= core_source;
                served_count <= served_count + 8'h01;
                wait_cnt <= 4'h0;
                busy_cnt <= 3'h4;
            end
            else if (core_request)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/interrupt_request_pending_regs_tb.sv
// testbench for the pending-request registers
`timescale 1ns/10ps
`default_nettype none
module interrupt_request_pending_regs_tb;
    import irq_pending_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] per_p = 8'h00;
    logic [7:0] port_p = 8'h00;
    logic [2:0] ev = 3'h0;
    logic [3:0] ack_delay = 4'h7;
    logic [7:0] reg_rdata, served_count, n;
    logic [3:0] core_source, served_source;
    logic [1:0] core_level;
    logic core_ack, core_request, gie, event_irq, iret;
    int fail_count = 0;
    int samples_checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    interrupt_request_pending_regs dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .timer2_pulse(per_p[7]), .timer1_pulse(per_p[6]),
        .timer0_pulse(per_p[5]), .serial0_receive_pulse(per_p[4]),
        .serial0_transmit_pulse(per_p[3]), .two_wire_pulse(per_p[2]),
        .serial_periph_pulse(per_p[1]), .converter_pulse(per_p[0]),
        .pin_a7_or_lowvolt_pulse(port_p[7]), .pin_a6_or_comp0_pulse(port_p[6]),
        .pin_a5_or_comp1_pulse(port_p[5]), .shared_port_pin_pulse(port_p[4:1]),
        .pin_a0_pulse(port_p[0]), .enable_interrupt_exec(ev[0]),
        .interrupt_return_exec(iret), .disable_interrupt_exec(ev[1]), .trap_exec(ev[2]),
        .core_ack, .core_request, .core_source, .core_level,
        .global_interrupt_enable(gie), .event_irq);
    core_model core (.ref_clk, .nrst, .core_request, .core_source, .ack_delay, .core_ack,
        .interrupt_return_exec(iret), .served_source, .served_count);
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    // one-cycle source pulses
    task automatic fire(input logic [7:0] pp, input logic [7:0] qp);
        @(posedge ref_clk);
        per_p <= pp;
        port_p <= qp;
        @(posedge ref_clk);
        per_p <= 8'h00;
        port_p <= 8'h00;
        #1;
    endtask
    task automatic evt(input logic [2:0] e, input logic exp);
        @(posedge ref_clk);
        ev <= e;
        @(posedge ref_clk);
        ev <= 3'h0;
        #1 check("global enable", {7'h00, gie}, {7'h00, exp});
    endtask
    task automatic wait_on(input logic [7:0] cnt, input logic req);
        for (int i = 0; i < 300 && !(served_count === cnt && core_request === req); i++)
            @(posedge ref_clk) #1;
        if (!(served_count === cnt && core_request === req))
        begin
            fail_count++;
            $display("ERROR core wait expected %h seen %h", cnt, served_count);
            conclude();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_map();
        logic [7:0] acc;
        acc = 8'h00;
        rd(PERIPH_PEND_ADDR, PEND_RESET);
        rd(PORT_PEND_ADDR, PEND_RESET);
        wr(12'hABC, 8'hFF);
        rd(12'hABC, READ_UNMAPPED);
        for (int i = 0; i < 8; i++)
        begin
            acc = acc | (8'h01 << i);
            fire(8'h01 << i, 8'h01 << i);
            rd(PERIPH_PEND_ADDR, acc);
            rd(PORT_PEND_ADDR, acc);
        end
        wr(PERIPH_PEND_ADDR, 8'h00);
        rd(PERIPH_PEND_ADDR, 8'h00);
        wr(PORT_PEND_ADDR, 8'hA5);
        rd(PORT_PEND_ADDR, 8'hA5);
        @(posedge ref_clk);
        reg_addr <= PERIPH_PEND_ADDR;
        reg_wdata <= 8'h00;
        reg_write <= 1'b1;
        per_p <= 8'h80;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        per_p <= 8'h00;
        #1 rd(PERIPH_PEND_ADDR, 8'h80);
    endtask
    task automatic test_events();
        wr(EVENT_STATUS_ADDR, 8'h07);
        wr(EVENT_MASK_ADDR, 8'h01);
        fire(8'h00, 8'h02);
        check("event irq", {7'h00, event_irq}, 8'h00);
        fire(8'h20, 8'h00);
        check("event irq", {7'h00, event_irq}, 8'h01);
        rd(EVENT_STATUS_ADDR, 8'h03);
        wr(EVENT_MASK_ADDR, 8'h00);
        check("event irq", {7'h00, event_irq}, 8'h00);
        wr(EVENT_STATUS_ADDR, 8'h03);
        rd(EVENT_STATUS_ADDR, 8'h00);
        wr(PERIPH_PEND_ADDR, 8'h00);
        wr(PORT_PEND_ADDR, 8'h00);
    endtask
    task automatic test_gie();
        evt(3'h1, 1'b1);
        evt(3'h2, 1'b0);
        evt(3'h1, 1'b1);
        evt(3'h4, 1'b0);
        wr(CONTROL_ADDR, 8'h80);
        rd(CONTROL_ADDR, 8'h80);
        wr(CONTROL_ADDR, 8'h00);
        rd(CONTROL_ADDR, 8'h00);
    endtask
    task automatic test_core();
        n = served_count;
        for (int lv = 1; lv < 4; lv++)
        begin
            wr(PORT_EN_HIGH_ADDR, {7'h00, lv[1]});
            wr(PORT_EN_LOW_ADDR, {7'h00, lv[0]});
            wr(CONTROL_ADDR, 8'h80);
            wr(PORT_PEND_ADDR, 8'h01);
            wait_on(n, 1'b1);
            check("core level", {6'h00, core_level}, lv[7:0]);
            check("core source", {4'h0, core_source}, 8'h00);
            n++;
            wait_on(n, 1'b0);
            rd(PORT_PEND_ADDR, 8'h00);
        end
        @(posedge ref_clk);
        ack_delay <= 4'h0;
        wr(PERIPH_EN_LOW_ADDR, 8'h80);
        wr(CONTROL_ADDR, 8'h80);
        fire(8'h80, 8'h01);
        wait_on(n + 8'h01, 1'b0);
        check("served", {4'h0, served_source}, 8'h00);
        wait_on(n + 8'h02, 1'b0);
        check("served", {4'h0, served_source}, 8'h0F);
        check("global enable", {7'h00, gie}, 8'h00);
        rd(PERIPH_PEND_ADDR, 8'h00);
        rd(EVENT_STATUS_ADDR, 8'h07);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        test_map();
        test_events();
        test_gie();
        test_core();
        conclude();
    end
endmodule
`default_nettype wire
